// *** rtl/servo_input_signal_logic.sv ***
// How it works
// RL1 - Enable turns servo on and ready only without alarm or warning 93.
// RL2 - Dropping enable turns the servo circuit off.
// RL3 - Brake setting 1 brakes when enable drops or halt is active.
// RL4 - Servo enable is fixed to input 1, normally open.
// RL5 - Active halt forces servo off and raises the halt alarm.
// RL6 - A mapped halt follows its pin state and configured polarity.
// RL7 - Unmapped halt is still evaluated; inverted unmapped halt alarms forever.
// RL8 - Alarms clear on an edge of alarm reset, never on level.
// RL9 - Reset works only for resettable alarms whose cause has gone.
// RL10 - After alarm reset, enable must be reasserted before ready.
// RL11 - Position mode clear edge adds deviation to command count, zeroes it.
// RL12 - Forward or reverse block stops drive in that direction only.
// RL13 - Pulses into a blocked direction grow deviation and raise excess alarm.
// RL14 - Position and speed mode setting picks drive off or servo lock.
// RL15 - Assign 0000 never, 0100 always, 000n pin on, 010n pin off.
// RL16 - Several functions may share one input, each evaluated alone.
// RL17 - Inputs are synchronised; each edge yields one single-cycle action.
// RL18 - Halt beats a same-cycle enable request; servo stays off.
`include "servo_input_regs.svh"

module servo_input_signal_logic (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // Opto-isolated discrete inputs, 1 = opto on
   input  wire logic [7:0]  discreteIn,
   // Drive-side status and pulses
   input  wire logic        mainLowVolt,
   input  wire logic        faultIn,
   input  wire logic        cmdPulse,
   input  wire logic        cmdDir,
   input  wire logic        fbPulse,
   input  wire logic        fbDir,
   // Drive controls
   output logic             servoOn,
   output logic             ready,
   output logic             dynamicBrake,
   output logic             fwdDriveOff,
   output logic             revDriveOff,
   output logic             servoLock,
   output logic             irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Input map decode
   function automatic logic fnActive(input logic [15:0] a, input logic [7:0] pins);
      logic [3:0] n;
      logic       hit;
      n = a[3:0];
      hit = 1'b0;
      if (a == `ASSIGN_ALWAYS) begin
         hit = 1'b1;
      end else if (a[15:9] == 7'h00 && a[7:4] == 4'h0 && n != 4'h0 && n <= 4'h8) begin
         hit = pins[3'(n - 4'h1)] ^ a[`ASSIGN_INV_BIT];
      end
      return hit;
   endfunction

   servo_input_pkg::state_t st;
   servo_input_pkg::state_t nx;
   logic [7:0]              pinLevel;
   logic [4:0]              funcActive;

   input_sync u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .rawIn   (discreteIn),
      .level   (pinLevel)
   ); // [RL17]

   generate
      for (genvar f = 0; f < `NUM_FUNCS; f++) begin : g_func
         assign funcActive[f] = fnActive(st.assignReg[f], pinLevel); // [RL6] [RL15] [RL16]
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   logic               enLevel;
   logic               haltActive;
   logic               clearEdge;
   logic               devClrEdge;
   logic               posMode;
   logic               lockApplies;
   logic               excess;
   logic               cleared;
   logic               run;
   logic [3:0]         w1c;
   logic [3:0]         evt;
   logic signed [15:0] cmdStep;
   logic signed [15:0] fbStep;
   logic [15:0]        devAbs;

   always_comb begin
      nx = st;
      w1c = 4'h0;
      enLevel = pinLevel[0]; // [RL4]
      haltActive = funcActive[0]; // [RL7]
      clearEdge = funcActive[1] & ~st.funcPrev[1]; // [RL8] [RL17]
      devClrEdge = funcActive[2] & ~st.funcPrev[2]; // [RL17]
      nx.funcPrev = funcActive;
      posMode = (st.mode == servo_input_pkg::MODE_POS);
      lockApplies = st.lockSel & (posMode | st.mode == servo_input_pkg::MODE_SPEED);
      nx.busReady = 1'b1;
      // Register writes in the data phase
      if (st.dataPhase && st.dataWrite) begin
         case (st.dataAddr)
            `OFS_HALT_ASSIGN:  nx.assignReg[0] = hwdata[15:0];
            `OFS_CLEAR_ASSIGN: nx.assignReg[1] = hwdata[15:0];
            `OFS_DEVCLR_ASSIGN: nx.assignReg[2] = hwdata[15:0];
            `OFS_FWD_ASSIGN:   nx.assignReg[3] = hwdata[15:0];
            `OFS_REV_ASSIGN:   nx.assignReg[4] = hwdata[15:0];
            `OFS_CONTROL: begin
               nx.mode = servo_input_pkg::control_mode_t'(hwdata[1:0]);
               nx.brakeSel = hwdata[`CTRL_BRAKE_BIT];
               nx.lockSel = hwdata[`CTRL_LOCK_BIT];
            end
            `OFS_EXCESS_LIMIT: nx.excessLimit = hwdata[15:0];
            `OFS_IRQ_STATUS:   w1c = hwdata[3:0];
            `OFS_IRQ_MASK:     nx.irqMask = hwdata[3:0];
            default: ;
         endcase
      end
      // Deviation counter; pulses into a blocked direction still accumulate
      cmdStep = cmdPulse ? (cmdDir ? 16'shFFFF : 16'sh0001) : 16'sh0000;
      fbStep = fbPulse ? (fbDir ? 16'shFFFF : 16'sh0001) : 16'sh0000;
      devAbs = st.deviation[15] ? 16'(-st.deviation) : st.deviation;
      excess = devAbs > st.excessLimit; // [RL13]
      nx.cmdCount = st.cmdCount + {{16{cmdStep[15]}}, cmdStep};
      if (posMode && devClrEdge) begin
         nx.cmdCount = nx.cmdCount + {{16{st.deviation[15]}}, st.deviation}; // [RL11]
         nx.deviation = 16'(cmdStep - fbStep); // [RL11]
      end else begin
         nx.deviation = 16'(st.deviation + cmdStep - fbStep); // [RL13]
      end
      // Alarm reset on edge, only once the cause is gone
      cleared = 1'b0;
      if (clearEdge) begin
         if (st.haltAlarm && !haltActive) begin
            nx.haltAlarm = 1'b0; // [RL8] [RL9]
            cleared = 1'b1;
         end
         if (st.excessAlarm && !excess) begin
            nx.excessAlarm = 1'b0; // [RL9]
            cleared = 1'b1;
         end
      end
      // Alarm sets win over a same-cycle reset
      if (haltActive) begin
         nx.haltAlarm = 1'b1; // [RL5]
      end
      if (excess) begin
         nx.excessAlarm = 1'b1; // [RL13]
      end
      if (faultIn) begin
         nx.faultAlarm = 1'b1; // [RL9]
      end
      if (cleared) begin
         nx.needReenable = 1'b1; // [RL10]
      end else if (!enLevel) begin
         nx.needReenable = 1'b0; // [RL10]
      end
      // Servo circuit and ready
      run = enLevel & ~haltActive & ~nx.haltAlarm & ~nx.excessAlarm & ~nx.faultAlarm
            & ~mainLowVolt & ~nx.needReenable; // [RL1] [RL2] [RL5] [RL18]
      nx.servoOn = run;
      nx.ready = run & st.servoOn; // [RL1]
      nx.brake = st.brakeSel & ~run & (~enLevel | haltActive | nx.haltAlarm); // [RL3]
      // Direction blocks
      nx.fwdOff = funcActive[3] & ~lockApplies; // [RL12] [RL14]
      nx.revOff = funcActive[4] & ~lockApplies; // [RL12] [RL14]
      nx.lock = (funcActive[3] | funcActive[4]) & lockApplies; // [RL14]
      // Interrupts
      evt[`IRQ_HALT] = nx.haltAlarm & ~st.haltAlarm;
      evt[`IRQ_EXCESS] = nx.excessAlarm & ~st.excessAlarm;
      evt[`IRQ_CLEARED] = cleared;
      evt[`IRQ_DEVCLR] = posMode & devClrEdge;
      nx.irqStat = (st.irqStat & ~w1c) | evt;
      nx.irq = |(nx.irqStat & nx.irqMask);
      // Address phase; read data prepared from the updated state
      nx.dataPhase = hsel & hready & htrans[1];
      nx.dataWrite = hwrite;
      nx.dataAddr = haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            `OFS_HALT_ASSIGN:   nx.rdata = {16'h0000, nx.assignReg[0]};
            `OFS_CLEAR_ASSIGN:  nx.rdata = {16'h0000, nx.assignReg[1]};
            `OFS_DEVCLR_ASSIGN: nx.rdata = {16'h0000, nx.assignReg[2]};
            `OFS_FWD_ASSIGN:    nx.rdata = {16'h0000, nx.assignReg[3]};
            `OFS_REV_ASSIGN:    nx.rdata = {16'h0000, nx.assignReg[4]};
            `OFS_CONTROL: nx.rdata = {28'h0000000, nx.lockSel, nx.brakeSel, nx.mode};
            `OFS_EXCESS_LIMIT:  nx.rdata = {16'h0000, nx.excessLimit};
            `OFS_STATUS: nx.rdata = {pinLevel, (mainLowVolt ? `LOW_VOLT_WARN_CODE : 8'h00),
                                     6'h00, nx.faultAlarm, nx.excessAlarm, nx.haltAlarm,
                                     nx.needReenable, nx.lock, nx.revOff, nx.fwdOff,
                                     nx.brake, nx.ready, nx.servoOn};
            `OFS_IRQ_STATUS:    nx.rdata = {28'h0000000, nx.irqStat};
            `OFS_IRQ_MASK:      nx.rdata = {28'h0000000, nx.irqMask};
            `OFS_DEVIATION:     nx.rdata = {{16{nx.deviation[15]}}, nx.deviation};
            `OFS_CMD_COUNT:     nx.rdata = nx.cmdCount;
            default:            nx.rdata = 32'h00000000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
         st.assignReg[0] <= `RST_HALT_ASSIGN;
         st.assignReg[1] <= `RST_CLEAR_ASSIGN;
         st.assignReg[2] <= `RST_DEVCLR_ASSIGN;
         st.assignReg[3] <= `RST_FWD_ASSIGN;
         st.assignReg[4] <= `RST_REV_ASSIGN;
         st.excessLimit <= `RST_EXCESS_LIMIT;
         st.funcPrev <= 5'h1F;
         st.busReady <= 1'b1;
      end else begin
         st <= nx;
      end
   end

   assign hreadyout = st.busReady;
   assign hrdata = st.rdata;
   assign hresp = 1'b0;
   assign servoOn = st.servoOn;
   assign ready = st.ready;
   assign dynamicBrake = st.brake;
   assign fwdDriveOff = st.fwdOff;
   assign revDriveOff = st.revOff;
   assign servoLock = st.lock;
   assign irq = st.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   halt_forces_off_a: assert property (haltActive |=> !servoOn && st.haltAlarm) // [RL5] [RL18]
      else $error("halt did not force servo off with alarm");
   ready_gate_a: assert property (ready |-> $past(enLevel) && !$past(mainLowVolt)
                                   && !st.haltAlarm && !st.excessAlarm) // [RL1]
      else $error("ready without enable or with alarm");
   enable_off_a: assert property (!enLevel |=> !servoOn ##1 !ready) // [RL2]
      else $error("servo stayed on after enable dropped");
   brake_on_a: assert property (st.brakeSel && (!enLevel || haltActive) |=> dynamicBrake) // [RL3]
      else $error("dynamic brake not engaged");
   reset_cause_a: assert property ($fell(st.haltAlarm) |-> $past(clearEdge)
                                    && !$past(haltActive)) // [RL8] [RL9]
      else $error("halt alarm cleared without edge or with cause");
   reenable_a: assert property ($rose(st.needReenable) |-> !servoOn [*2]) // [RL10]
      else $error("servo on before enable reasserted");
   dev_clear_a: assert property (posMode && devClrEdge && !cmdPulse && !fbPulse |=>
      st.deviation == 16'sh0000
      && st.cmdCount == $past(st.cmdCount) + {{16{$past(st.deviation[15])}},
                                               $past(st.deviation)}) // [RL11]
      else $error("deviation clear wrong");
   fwd_block_a: assert property (funcActive[3] && !lockApplies |=> fwdDriveOff
                                  && (revDriveOff == $past(funcActive[4]))) // [RL12] [RL14]
      else $error("forward block misapplied");
   lock_mode_a: assert property (funcActive[4] && lockApplies |=> servoLock && !revDriveOff) // [RL14]
      else $error("servo lock not applied");
   excess_a: assert property (excess |=> st.excessAlarm ##1 !ready) // [RL13]
      else $error("excess deviation alarm missing");
   map_never_a: assert property (st.assignReg[0] == 16'h0000 |-> !funcActive[0]) // [RL15] [RL7]
      else $error("unassigned halt active");
   edge_single_a: assert property (clearEdge |=> !clearEdge) // [RL17]
      else $error("edge lasted more than one cycle");
   low_volt_a: assert property (mainLowVolt |=> !servoOn) // [RL1]
      else $error("servo on during low voltage warning");
   brake_off_a: assert property (!st.brakeSel |=> !dynamicBrake) // [RL3]
      else $error("dynamic brake without setting");
   excess_keep_a: assert property (st.excessAlarm && excess |=> st.excessAlarm) // [RL9]
      else $error("excess alarm cleared while deviation too large");
   fault_keep_a: assert property (st.faultAlarm |=> st.faultAlarm) // [RL9]
      else $error("fault alarm cleared without reset");
   clear_mode_a: assert property (!posMode && !cmdPulse && !fbPulse |=> // [RL11]
      $stable(st.deviation))
      else $error("deviation changed outside position mode");

   alarm_reset_c: cover property (st.haltAlarm ##1 !st.haltAlarm ##[1:20] servoOn);
   dev_clear_c: cover property (posMode && devClrEdge && st.deviation != 16'sh0000);
   excess_c: cover property (funcActive[3] && st.excessAlarm);
   irq_c: cover property ($rose(irq));
   lock_c: cover property (servoLock && !fwdDriveOff);

endmodule

// *** rtl/servo_input_regs.svh ***
`ifndef SERVO_INPUT_REGS_SVH
`define SERVO_INPUT_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFS_HALT_ASSIGN     8'h00
`define OFS_CLEAR_ASSIGN    8'h04
`define OFS_DEVCLR_ASSIGN   8'h08
`define OFS_FWD_ASSIGN      8'h0C
`define OFS_REV_ASSIGN      8'h10
`define OFS_CONTROL         8'h14
`define OFS_EXCESS_LIMIT    8'h18
`define OFS_STATUS          8'h1C
`define OFS_IRQ_STATUS      8'h20
`define OFS_IRQ_MASK        8'h24
`define OFS_DEVIATION       8'h28
`define OFS_CMD_COUNT       8'h2C

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_HALT_ASSIGN     16'h0000
`define RST_CLEAR_ASSIGN    16'h0002
`define RST_DEVCLR_ASSIGN   16'h0003
`define RST_FWD_ASSIGN      16'h0104
`define RST_REV_ASSIGN      16'h0105
`define RST_EXCESS_LIMIT    16'h1000

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define ASSIGN_ALWAYS       16'h0100
`define ASSIGN_INV_BIT      8
`define CTRL_BRAKE_BIT      2
`define CTRL_LOCK_BIT       3
`define IRQ_HALT            0
`define IRQ_EXCESS          1
`define IRQ_CLEARED         2
`define IRQ_DEVCLR          3
`define LOW_VOLT_WARN_CODE  8'h5D
`define NUM_INPUTS          8
`define NUM_FUNCS           5

`endif

// *** rtl/servo_input_pkg.sv ***
package servo_input_pkg;

   typedef enum logic [1:0] {MODE_POS, MODE_SPEED, MODE_TORQUE, MODE_SPARE} control_mode_t;

   typedef struct packed {
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] lvl;
   } sync_t;

   typedef struct packed {
      logic [4:0][15:0]   assignReg;
      control_mode_t      mode;
      logic               brakeSel;
      logic               lockSel;
      logic [15:0]        excessLimit;
      logic [3:0]         irqStat;
      logic [3:0]         irqMask;
      logic               irq;
      logic               haltAlarm;
      logic               excessAlarm;
      logic               faultAlarm;
      logic               needReenable;
      logic               servoOn;
      logic               ready;
      logic               brake;
      logic               fwdOff;
      logic               revOff;
      logic               lock;
      logic [4:0]         funcPrev;
      logic signed [15:0] deviation;
      logic [31:0]        cmdCount;
      logic               busReady;
      logic               dataPhase;
      logic               dataWrite;
      logic [7:0]         dataAddr;
      logic [31:0]        rdata;
   } state_t;

endpackage

// *** rtl/input_sync.sv ***
module input_sync (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Raw opto inputs and filtered levels
   input  wire logic [7:0] rawIn,
   output logic      [7:0] level
);

   servo_input_pkg::sync_t st;
   servo_input_pkg::sync_t nx;

   // Three stages; level follows once stages two and three agree
   always_comb begin
      nx = st;
      nx.s1 = rawIn;
      nx.s2 = st.s1;
      nx.s3 = st.s2;
      for (int i = 0; i < 8; i++) begin
         if (st.s2[i] == st.s3[i]) begin
            nx.lvl[i] = st.s3[i];
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   assign level = st.lvl;

endmodule

// *** test/host_motion_model.sv ***
module host_motion_model (
   // Clock
   input  wire logic       clk,
   // Opto inputs and pulse train toward the drive
   output logic      [7:0] discreteIn,
   output logic            cmdPulse,
   output logic            cmdDir,
   output logic            fbPulse,
   output logic            fbDir
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      discreteIn = 8'h18;
      cmdPulse   = 1'b0;
      cmdDir     = 1'b0;
      fbPulse    = 1'b0;
      fbDir      = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Opto levels, changed just after an edge
   task automatic setPins(input logic [7:0] m, input logic [7:0] v);
      @(posedge clk);
      discreteIn <= (discreteIn & ~m) | (v & m);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // One pulse per cycle; direction inverted once the burst ends
   task automatic pulses(input int n, input logic dir, input logic fb);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         cmdPulse <= !fb;
         cmdDir   <= fb ? !dir : dir;
         fbPulse  <= fb;
         fbDir    <= fb ? dir : !dir;
      end
      @(posedge clk);
      cmdPulse <= 1'b0;
      fbPulse  <= 1'b0;
      cmdDir   <= !cmdDir;
      fbDir    <= !fbDir;
   endtask
endmodule

// *** test/servo_input_signal_logic_bench.sv ***
`include "servo_input_regs.svh"

module servo_input_signal_logic_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        sys_rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic [7:0]  discreteIn;
   logic        mainLowVolt;
   logic        faultIn;
   logic        cmdPulse;
   logic        cmdDir;
   logic        fbPulse;
   logic        fbDir;
   logic        servoOn;
   logic        ready;
   logic        dynamicBrake;
   logic        fwdDriveOff;
   logic        revDriveOff;
   logic        servoLock;
   logic        irq;
   int          seed = 36;
   int          n_errors = 0;
   int          n_checks = 0;
   int          cnt;
   logic [31:0] rd;
   logic [31:0] cmd0;
   logic [15:0] code;
   logic [7:0]  pins;

   servo_input_signal_logic u_dut (
      .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .discreteIn(discreteIn),
      .mainLowVolt(mainLowVolt), .faultIn(faultIn), .cmdPulse(cmdPulse), .cmdDir(cmdDir),
      .fbPulse(fbPulse), .fbDir(fbDir), .servoOn(servoOn), .ready(ready),
      .dynamicBrake(dynamicBrake), .fwdDriveOff(fwdDriveOff), .revDriveOff(revDriveOff),
      .servoLock(servoLock), .irq(irq));

   host_motion_model u_host (
      .clk(clk), .discreteIn(discreteIn), .cmdPulse(cmdPulse), .cmdDir(cmdDir),
      .fbPulse(fbPulse), .fbDir(fbDir));

   assign hready = hreadyout;

   always #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic assignActive(input logic [15:0] c, input logic [7:0] p);
      if (c == 16'h0100) return 1'b1;
      if (c[3:0] >= 4'h1 && c[3:0] <= 4'h8 && c[15:4] == 12'h000) return p[c[3:0] - 4'h1];
      if (c[3:0] >= 4'h1 && c[3:0] <= 4'h8 && c[15:4] == 12'h010) return !p[c[3:0] - 4'h1];
      return 1'b0;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic busCycle(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      hsel   <= 1'b0;
      hwdata <= ~d;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      busCycle(a, 1'b1, d);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
      busCycle(a, 1'b0, 32'h00000000);
      check(rd, exp);
   endtask

   task automatic settle;
      repeat (8) @(posedge clk);
   endtask

   task automatic pulsePin(input logic [7:0] m);
      u_host.setPins(m, m);
      settle();
      u_host.setPins(m, 8'h00);
      settle();
   endtask

   task automatic summarize;
      $display("Checks %0d, errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 1'b0; sys_rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
      hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0; mainLowVolt = 1'b0; faultIn = 1'b0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rdChk(`OFS_HALT_ASSIGN, 32'h00000000);
      rdChk(`OFS_CLEAR_ASSIGN, 32'h00000002);
      rdChk(`OFS_DEVCLR_ASSIGN, 32'h00000003);
      rdChk(`OFS_FWD_ASSIGN, 32'h00000104);
      rdChk(`OFS_REV_ASSIGN, 32'h00000105);
      rdChk(8'h40, 32'h00000000);
      wr(`OFS_IRQ_MASK, 32'h0000000F);
      wr(`OFS_CONTROL, 32'h00000004);
      u_host.setPins(8'h01, 8'h01);
      settle();
      check({servoOn, ready, dynamicBrake}, 32'h6);
      u_host.setPins(8'h01, 8'h00);
      settle();
      check({servoOn, ready, dynamicBrake}, 32'h1);
      mainLowVolt <= 1'b1;
      u_host.setPins(8'h01, 8'h01);
      settle();
      check({servoOn, ready}, 32'h0);
      busCycle(`OFS_STATUS, 1'b0, 32'h0);
      check(rd[23:16], 32'h5D);
      mainLowVolt <= 1'b0;
      u_host.setPins(8'h01, 8'h00);
      wr(`OFS_HALT_ASSIGN, 32'h00000006);
      u_host.setPins(8'h21, 8'h21);
      settle();
      check({servoOn, ready}, 32'h0);
      check(dynamicBrake, 32'h1);
      check(irq, 32'h1);
      rdChk(`OFS_IRQ_STATUS, 32'h00000001);
      u_host.setPins(8'h02, 8'h02);
      settle();
      u_host.setPins(8'h20, 8'h00);
      settle();
      busCycle(`OFS_STATUS, 1'b0, 32'h0);
      check(rd[7], 32'h1);
      u_host.setPins(8'h02, 8'h00);
      settle();
      u_host.setPins(8'h02, 8'h02);
      settle();
      busCycle(`OFS_STATUS, 1'b0, 32'h0);
      check(rd[9:7], 32'h0);
      check({servoOn, ready}, 32'h0);
      rdChk(`OFS_IRQ_STATUS, 32'h00000005);
      wr(`OFS_IRQ_STATUS, 32'h0000000F);
      settle();
      check(irq, 32'h0);
      u_host.setPins(8'h01, 8'h00);
      settle();
      u_host.setPins(8'h01, 8'h01);
      settle();
      check({servoOn, ready}, 32'h3);
      wr(`OFS_HALT_ASSIGN, 32'h00000100);
      settle();
      busCycle(`OFS_STATUS, 1'b0, 32'h0);
      check({rd[7], servoOn}, 32'h2);
      wr(`OFS_HALT_ASSIGN, 32'h00000000);
      pulsePin(8'h02);
      u_host.setPins(8'h09, 8'h00);
      for (int m = 0; m < 8; m++) begin
         wr(`OFS_CONTROL, {28'h0, m[2], 1'b0, m[1:0]});
         settle();
         check(servoLock, {31'h0, m[2] && m[1:0] < 2'd2});
         check(dynamicBrake, 32'h0);
         check({fwdDriveOff, revDriveOff}, {30'h0, !(m[2] && m[1:0] < 2'd2), 1'b0});
      end
      wr(`OFS_CONTROL, 32'h00000000);
      for (int i = 0; i < 16; i++) begin
         pins = 8'($random(seed));
         code = 16'(1 + ($random(seed) & 7));
         code = (i % 4 == 0) ? 16'h0000 : (i % 4 == 1) ? 16'h0100 : (i % 4 == 2) ? code :
                (code | 16'h0100);
         wr(`OFS_FWD_ASSIGN, {16'h0, code});
         wr(`OFS_REV_ASSIGN, {16'h0, code});
         u_host.setPins(8'hFE, pins);
         settle();
         check({fwdDriveOff, revDriveOff}, {30'h0, {2{assignActive(code, discreteIn)}}});
      end
      wr(`OFS_FWD_ASSIGN, 32'h00000104);
      wr(`OFS_REV_ASSIGN, 32'h00000105);
      u_host.setPins(8'hFF, 8'h18);
      wr(`OFS_IRQ_STATUS, 32'h0000000F);
      wr(`OFS_IRQ_MASK, 32'h00000007);
      cnt = 3 + ($random(seed) & 15);
      u_host.pulses(cnt, 1'b1, 1'b0);
      u_host.pulses(2, 1'b1, 1'b1);
      settle();
      rdChk(`OFS_DEVIATION, 32'(2 - cnt));
      busCycle(`OFS_CMD_COUNT, 1'b0, 32'h0);
      cmd0 = rd;
      pulsePin(8'h04);
      rdChk(`OFS_DEVIATION, 32'h00000000);
      rdChk(`OFS_CMD_COUNT, cmd0 + 32'(2 - cnt));
      rdChk(`OFS_IRQ_STATUS, 32'h00000008);
      check(irq, 32'h0);
      wr(`OFS_CONTROL, 32'h00000001);
      u_host.pulses(3, 1'b0, 1'b0);
      pulsePin(8'h04);
      rdChk(`OFS_DEVIATION, 32'h00000003);
      wr(`OFS_CONTROL, 32'h00000000);
      pulsePin(8'h04);
      rdChk(`OFS_DEVIATION, 32'h00000000);
      wr(`OFS_EXCESS_LIMIT, 32'h00000004);
      u_host.pulses(4, 1'b0, 1'b0);
      settle();
      busCycle(`OFS_STATUS, 1'b0, 32'h0);
      check(rd[8], 32'h0);
      u_host.pulses(1, 1'b0, 1'b0);
      settle();
      busCycle(`OFS_STATUS, 1'b0, 32'h0);
      check({rd[8], irq}, 32'h3);
      faultIn <= 1'b1;
      @(posedge clk);
      faultIn <= 1'b0;
      pulsePin(8'h02);
      busCycle(`OFS_STATUS, 1'b0, 32'h0);
      check({rd[9], servoOn}, 32'h2);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      busCycle(`OFS_STATUS, 1'b0, 32'h0);
      check(rd[9:7], 32'h0);
      summarize();
   end
endmodule
